/* verilog/parity_report_pkg.sv */
// Purpose: Shared constants and types of the bridge data parity reporting block.
// Assumes: 8-bit register address, 32-bit register data.
// Notes: Each register takes one aligned 32-bit word.
package parity_report_pkg;

	// Transaction kinds that the forwarding logic reports.
	typedef enum logic [1:0]
	{
		XACT_READ,
		XACT_POSTED_WRITE,
		XACT_DELAYED_WRITE
	} xact_t;

	// Register geometry.
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;

	// Control register fields.
	localparam int          CTRL_PRI_EN_BIT = 0;
	localparam int          CTRL_SEC_EN_BIT = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;

	// Status register fields.
	localparam int          STAT_PRI_DPD_BIT   = 0;
	localparam int          STAT_SEC_DPD_BIT   = 1;
	localparam int          STAT_PRI_DRIVE_BIT = 2;
	localparam int          STAT_SEC_DRIVE_BIT = 3;
	localparam logic [1:0]  STATUS_RESET       = 2'h0;

	// Read data returned outside a read cycle or for an unmapped address.
	localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage

/* verilog/parity_eval_if.sv */
// Purpose: Carries one bus's parity evaluation inputs and verdicts.
// Assumes: All signals are sampled on the bridge clock.
// Notes: "Here" is the bus being judged, "other" the opposite bus.
`timescale 1ns/1ps
interface parity_eval_if;
	import parity_report_pkg::*;

	logic  valid;       // One-cycle report of a finished data phase.
	xact_t kind;        // Transaction type.
	logic  away;        // Bridge is master on this bus for the transfer.
	logic  err_here;    // Bridge saw bad parity on this bus.
	logic  pin_here;    // Parity error pin of this bus seen asserted.
	logic  pin_other;   // Parity error pin of the opposite bus seen asserted.
	logic  en_here;     // Response enable of this bus.
	logic  en_other;    // Response enable of the opposite bus.
	logic  dpd_set;     // Set the data-parity-detected bit of this bus.
	logic  perr_assert; // Drive this bus's parity error pin low.

	modport eval
	(
		input  valid, kind, away, err_here, pin_here, pin_other, en_here, en_other,
		output dpd_set, perr_assert
	);

	modport ctrl
	(
		output valid, kind, away, err_here, pin_here, pin_other, en_here, en_other,
		input  dpd_set, perr_assert
	);

endinterface

/* verilog/parity_bus_eval.sv */
// Purpose: Judges one bus: status set and parity error pin decision.
// Assumes: Inputs are a single-cycle report from the forwarding logic.
// Notes: Purely combinational; the same module serves both buses mirrored.
`timescale 1ns/1ps
module parity_bus_eval
	import parity_report_pkg::*;
(
	parity_eval_if.eval bus
);

	// Decoded roles of the bridge on this bus.
	wire is_read      = (bus.kind == XACT_READ);
	wire is_write     = (bus.kind == XACT_POSTED_WRITE) || (bus.kind == XACT_DELAYED_WRITE);
	wire is_delayed   = (bus.kind == XACT_DELAYED_WRITE);
	wire seen_here    = bus.err_here || bus.pin_here;
	// Bridge is initiator of a read or target of a write on this bus.
	wire drives_perr  = (is_read && bus.away) || (is_write && !bus.away);

	// Only a master on this bus records a detected data parity error.
	assign bus.dpd_set = bus.valid && bus.away && seen_here && bus.en_here;

	// Own parity error, or the far pin reported on a delayed write completion.
	wire own_err      = drives_perr && bus.err_here && bus.en_here;
	wire forwarded    = is_delayed && !bus.away && bus.pin_other
		&& bus.en_here && bus.en_other;

	assign bus.perr_assert = bus.valid && (own_err || forwarded);

endmodule

/* verilog/bridge_data_parity_reporting.sv */
// Purpose: Data parity status bits and parity error pin drive of a bridge.
// Assumes: One transaction report per cycle, inputs synchronous to i_mclk.
// Notes: Pins are sustained tri-state: low, one cycle high, then released.
`timescale 1ns/1ps

// What this block does
// - Primary detected bit needs bridge primary master
// - Upstream transfers, primary error, enable: set
// - Secondary detected bit needs bridge secondary master
// - Downstream transfers, secondary error, enable: set
// - Primary pin: write target or read initiator
// - Downstream delayed write far pin forwards primary
// - Primary pin low for its table cases
// - Secondary pin: role, enable, own error
// - Upstream delayed write far pin forwards secondary
// - Forwarding to secondary needs both enables
module bridge_data_parity_reporting
	import parity_report_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_nrst,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic              i_xact_valid,
	input  wire xact_t             i_xact_kind,
	input  wire logic              i_xact_upstream,
	input  wire logic              i_pri_data_err,
	input  wire logic              i_sec_data_err,
	input  wire logic              i_primary_parity_error_pin_in_n,
	input  wire logic              i_secondary_parity_error_pin_in_n,
	output logic                   o_primary_parity_error_pin_n,
	output logic                   o_primary_parity_error_pin_oe,
	output logic                   o_secondary_parity_error_pin_n,
	output logic                   o_secondary_parity_error_pin_oe
);

	// Reset release through two flops; assertion stays asynchronous.
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// Register state.
	logic [1:0]        ctrl_reg;
	logic [1:0]        ctrl_next;
	logic [1:0]        status_reg;
	logic [1:0]        status_next;
	logic [DATA_W-1:0] rdata_next;

	// Address decode and write strobes.
	wire sel_ctrl   = (i_addr == CTRL_OFFSET);
	wire sel_status = (i_addr == STATUS_OFFSET);
	wire wr_ctrl    = i_wr && sel_ctrl;
	wire wr_status  = i_wr && sel_status;
	wire pri_en     = ctrl_reg[CTRL_PRI_EN_BIT];
	wire sec_en     = ctrl_reg[CTRL_SEC_EN_BIT];

	// Incoming pins are active low; work internally with asserted levels.
	wire pri_pin    = !i_primary_parity_error_pin_in_n;
	wire sec_pin    = !i_secondary_parity_error_pin_in_n;

	// One evaluator per bus, mirrored on direction and enables.
	parity_eval_if pri_if ();
	parity_eval_if sec_if ();

	assign pri_if.valid     = i_xact_valid;
	assign pri_if.kind      = i_xact_kind;
	assign pri_if.away      = i_xact_upstream;
	assign pri_if.err_here  = i_pri_data_err;
	assign pri_if.pin_here  = pri_pin;
	assign pri_if.pin_other = sec_pin;
	assign pri_if.en_here   = pri_en;
	assign pri_if.en_other  = sec_en;

	assign sec_if.valid     = i_xact_valid;
	assign sec_if.kind      = i_xact_kind;
	assign sec_if.away      = !i_xact_upstream;
	assign sec_if.err_here  = i_sec_data_err;
	assign sec_if.pin_here  = sec_pin;
	assign sec_if.pin_other = pri_pin;
	assign sec_if.en_here   = sec_en;
	assign sec_if.en_other  = pri_en;

	parity_bus_eval u_pri_eval
	(
		.bus (pri_if)
	);

	parity_bus_eval u_sec_eval
	(
		.bus (sec_if)
	);

	// Status bits set by hardware, cleared by writing one; a set wins.
	wire [1:0] dpd_set = {sec_if.dpd_set, pri_if.dpd_set};
	wire [1:0] w1c     = wr_status ? i_wdata[1:0] : 2'h0;

	assign ctrl_next   = wr_ctrl ? i_wdata[1:0] : ctrl_reg;
	assign status_next = (status_reg & ~w1c) | dpd_set;

	// Read mux; data stands only in the cycle after the read strobe.
	wire [DATA_W-1:0] ctrl_word   = {30'h0, ctrl_reg};
	wire [DATA_W-1:0] status_word = {28'h0, !o_secondary_parity_error_pin_n,
		!o_primary_parity_error_pin_n, status_reg};

	assign rdata_next = !i_rd     ? RDATA_IDLE :
		sel_ctrl   ? ctrl_word :
		sel_status ? status_word : RDATA_IDLE;

	always_ff @(posedge i_mclk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ctrl_reg   <= CTRL_RESET;
			status_reg <= STATUS_RESET;
			o_rdata    <= RDATA_IDLE;
		end
		else
		begin
			ctrl_reg   <= ctrl_next;
			status_reg <= status_next;
			o_rdata    <= rdata_next;
		end
	end

	// Pin drive: low on assertion, then one cycle driven high before release,
	// so the shared line returns high quickly instead of floating up slowly.
	wire pri_oe_next = pri_if.perr_assert
		|| (o_primary_parity_error_pin_oe && !o_primary_parity_error_pin_n);
	wire sec_oe_next = sec_if.perr_assert
		|| (o_secondary_parity_error_pin_oe && !o_secondary_parity_error_pin_n);

	always_ff @(posedge i_mclk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			o_primary_parity_error_pin_n    <= 1'b1;
			o_primary_parity_error_pin_oe   <= 1'b0;
			o_secondary_parity_error_pin_n  <= 1'b1;
			o_secondary_parity_error_pin_oe <= 1'b0;
		end
		else
		begin
			o_primary_parity_error_pin_n    <= !pri_if.perr_assert;
			o_primary_parity_error_pin_oe   <= pri_oe_next;
			o_secondary_parity_error_pin_n  <= !sec_if.perr_assert;
			o_secondary_parity_error_pin_oe <= sec_oe_next;
		end
	end

	// Checks of the reporting behaviour.
	wire up_any   = i_xact_valid && i_xact_upstream;
	wire down_any = i_xact_valid && !i_xact_upstream;
	wire rd_k     = (i_xact_kind == XACT_READ);
	wire dw_k     = (i_xact_kind == XACT_DELAYED_WRITE);
	wire wr_k     = !rd_k;

	sequence s_pri_low;
		!o_primary_parity_error_pin_n && o_primary_parity_error_pin_oe;
	endsequence

	sequence s_pri_release;
		(o_primary_parity_error_pin_n && o_primary_parity_error_pin_oe)
		##1 !o_primary_parity_error_pin_oe;
	endsequence

	sequence s_sec_low;
		!o_secondary_parity_error_pin_n && o_secondary_parity_error_pin_oe;
	endsequence

	sequence s_sec_release;
		(o_secondary_parity_error_pin_n && o_secondary_parity_error_pin_oe)
		##1 !o_secondary_parity_error_pin_oe;
	endsequence

	property p_pri_dpd_cause;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		$rose(status_reg[STAT_PRI_DPD_BIT]) |->
			$past(up_any && pri_en && (i_pri_data_err || pri_pin));
	endproperty
	a_pri_dpd_cause: assert property (p_pri_dpd_cause) else $error("primary bit set without cause");

	property p_pri_dpd_set;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(up_any && pri_en && (i_pri_data_err || pri_pin)) |=> status_reg[STAT_PRI_DPD_BIT];
	endproperty
	a_pri_dpd_set: assert property (p_pri_dpd_set) else $error("primary bit not set");

	property p_sec_dpd_cause;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		$rose(status_reg[STAT_SEC_DPD_BIT]) |->
			$past(down_any && sec_en && (i_sec_data_err || sec_pin));
	endproperty
	a_sec_dpd_cause: assert property (p_sec_dpd_cause) else $error("secondary bit set without cause");

	property p_sec_dpd_set;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(down_any && sec_en && (i_sec_data_err || sec_pin)) |=> status_reg[STAT_SEC_DPD_BIT];
	endproperty
	a_sec_dpd_set: assert property (p_sec_dpd_set) else $error("secondary bit not set");

	property p_pri_pin_enable;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		$fell(o_primary_parity_error_pin_n) |-> $past(pri_en);
	endproperty
	a_pri_pin_enable: assert property (p_pri_pin_enable) else $error("primary pin without enable");

	property p_pri_forward;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(down_any && dw_k && sec_pin && pri_en && sec_en) |=> s_pri_low;
	endproperty
	a_pri_forward: assert property (p_pri_forward) else $error("primary pin not forwarded");

	// Back-to-back reports may keep a pin low, so the release is only
	// checked when no new assertion follows the low cycle.
	property p_pri_release;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(!o_primary_parity_error_pin_n && o_primary_parity_error_pin_oe
			&& !pri_if.perr_assert) ##1 !pri_if.perr_assert |-> s_pri_release;
	endproperty
	a_pri_release: assert property (p_pri_release) else $error("primary pin not released");

	property p_pri_own;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(i_xact_valid && i_pri_data_err && pri_en
			&& ((i_xact_upstream && rd_k) || (!i_xact_upstream && wr_k))) |=> s_pri_low;
	endproperty
	a_pri_own: assert property (p_pri_own) else $error("primary pin not asserted");

	property p_pri_quiet;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(!i_xact_valid || !pri_en) |=> o_primary_parity_error_pin_n;
	endproperty
	a_pri_quiet: assert property (p_pri_quiet) else $error("primary pin asserted spuriously");

	property p_sec_quiet;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(!i_xact_valid || !sec_en) |=> o_secondary_parity_error_pin_n;
	endproperty
	a_sec_quiet: assert property (p_sec_quiet) else $error("secondary pin asserted spuriously");

	property p_sec_own;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(i_xact_valid && i_sec_data_err && sec_en
			&& ((!i_xact_upstream && rd_k) || (i_xact_upstream && wr_k)))
			|=> !o_secondary_parity_error_pin_n;
	endproperty
	a_sec_own: assert property (p_sec_own) else $error("secondary pin not asserted");

	property p_sec_forward;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(up_any && dw_k && pri_pin && pri_en && sec_en) |=> s_sec_low;
	endproperty
	a_sec_forward: assert property (p_sec_forward) else $error("secondary pin not forwarded");

	property p_sec_release;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(!o_secondary_parity_error_pin_n && o_secondary_parity_error_pin_oe
			&& !sec_if.perr_assert) ##1 !sec_if.perr_assert |-> s_sec_release;
	endproperty
	a_sec_release: assert property (p_sec_release) else $error("secondary pin not released");

	property p_sec_forward_gate;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(up_any && dw_k && !i_sec_data_err && !(pri_en && sec_en))
			|=> o_secondary_parity_error_pin_n;
	endproperty
	a_sec_forward_gate: assert property (p_sec_forward_gate) else $error("secondary pin ungated");

	property p_dpd_sticky;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(status_reg[STAT_PRI_DPD_BIT] && !(wr_status && i_wdata[STAT_PRI_DPD_BIT]))
			|=> status_reg[STAT_PRI_DPD_BIT];
	endproperty
	a_dpd_sticky: assert property (p_dpd_sticky) else $error("primary bit lost");

	property p_sec_dpd_sticky;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(status_reg[STAT_SEC_DPD_BIT] && !(wr_status && i_wdata[STAT_SEC_DPD_BIT]))
			|=> status_reg[STAT_SEC_DPD_BIT];
	endproperty
	a_sec_dpd_sticky: assert property (p_sec_dpd_sticky) else $error("secondary bit lost");

	// A clear only shows when no new error lands in the same cycle.
	property p_pri_dpd_clear;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(wr_status && i_wdata[STAT_PRI_DPD_BIT] && !pri_if.dpd_set)
			|=> !status_reg[STAT_PRI_DPD_BIT];
	endproperty
	a_pri_dpd_clear: assert property (p_pri_dpd_clear) else $error("primary bit not cleared");

	property p_dpd_clear;
		@(posedge i_mclk) disable iff (!rst_n_reg)
		(wr_status && i_wdata[STAT_SEC_DPD_BIT] && !sec_if.dpd_set)
			|=> !status_reg[STAT_SEC_DPD_BIT];
	endproperty
	a_dpd_clear: assert property (p_dpd_clear) else $error("secondary bit not cleared");

endmodule

/* dv/far_pci_agents.sv */
// Purpose: Far-side PCI agents that share both parity error wires with the bridge.
// Assumes: Each wire has a pull-up; an agent pulls low only while asked to.
// Notes: An agent lets go at once when its request drops, so no stale low lingers.
`timescale 1ns/1ps
module far_pci_agents
(
	input  wire logic i_pri_req,
	input  wire logic i_sec_req,
	input  wire logic i_pri_dut_n,
	input  wire logic i_pri_dut_oe,
	input  wire logic i_sec_dut_n,
	input  wire logic i_sec_dut_oe,
	output logic      o_pri_wire_n,
	output logic      o_sec_wire_n
);
	// Wired-AND of all drivers; the pull-up wins when nobody pulls the wire low.
	assign o_pri_wire_n = !(i_pri_req || (i_pri_dut_oe && !i_pri_dut_n));
	assign o_sec_wire_n = !(i_sec_req || (i_sec_dut_oe && !i_sec_dut_n));
endmodule

/* dv/bridge_data_parity_reporting_bench.sv */
// Purpose: Self-checking bench for the bridge data parity reporting block.
// Assumes: Fixed one-cycle answer to every report and every read.
// Notes: Sweeps every kind, direction, error source and enable pair.
`timescale 1ns/1ps
module bridge_data_parity_reporting_bench;
	import parity_report_pkg::*;

	logic        i_mclk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        xv = 1'b0;
	xact_t       xk = XACT_READ;
	logic        xup = 1'b0;
	logic        perr = 1'b0;
	logic        serr = 1'b0;
	logic        preq = 1'b0;
	logic        sreq = 1'b0;
	logic [31:0] o_rdata;
	logic        pn, poe, sn, soe, pw, sw;
	int          error_cnt = 0;
	int          checks_done = 0;

	// The clock runs at 125 MHz.
	always #4 i_mclk = ~i_mclk;

	bridge_data_parity_reporting bridge_data_parity_reporting_inst
	(
		.i_mclk                            (i_mclk),
		.i_nrst                            (i_nrst),
		.i_addr                            (i_addr),
		.i_wdata                           (i_wdata),
		.i_wr                              (i_wr),
		.i_rd                              (i_rd),
		.o_rdata                           (o_rdata),
		.i_xact_valid                      (xv),
		.i_xact_kind                       (xk),
		.i_xact_upstream                   (xup),
		.i_pri_data_err                    (perr),
		.i_sec_data_err                    (serr),
		.i_primary_parity_error_pin_in_n   (pw),
		.i_secondary_parity_error_pin_in_n (sw),
		.o_primary_parity_error_pin_n      (pn),
		.o_primary_parity_error_pin_oe     (poe),
		.o_secondary_parity_error_pin_n    (sn),
		.o_secondary_parity_error_pin_oe   (soe)
	);

	far_pci_agents far_pci_agents_inst
	(
		.i_pri_req    (preq),
		.i_sec_req    (sreq),
		.i_pri_dut_n  (pn),
		.i_pri_dut_oe (poe),
		.i_sec_dut_n  (sn),
		.i_sec_dut_oe (soe),
		.o_pri_wire_n (pw),
		.o_sec_wire_n (sw)
	);

	// Counts every comparison and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	// One report cycle; the far agent pulls its pin only while the report is valid.
	task automatic report(input xact_t k, input logic u, pe, se, pp, sp);
		@(posedge i_mclk);
		xv <= 1'b1;
		xk <= k;
		xup <= u;
		perr <= pe;
		serr <= se;
		preq <= pp;
		sreq <= sp;
		@(posedge i_mclk);
		xv <= 1'b0;
		{perr, serr, preq, sreq} <= 4'h0;
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: reset values, full decision sweep, then stickiness.
	initial
	begin
		logic [31:0] rd;
		logic        en_p, en_s, pe, se, pp, sp, wr, dly, pd, sd, ppin, spin;
		repeat (5) @(posedge i_mclk);
		check({30'h0, poe, pn}, 32'h1);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		reg_rd(CTRL_OFFSET, rd);
		check(rd, 32'h0);
		reg_rd(STATUS_OFFSET, rd);
		check(rd, 32'h0);
		reg_rd(8'h08, rd);
		check(rd, 32'h0);
		for (int e = 0; e < 4; e++)
		begin
			reg_wr(CTRL_OFFSET, e);
			reg_rd(CTRL_OFFSET, rd);
			check(rd, e);
			for (int k = 0; k < 3; k++)
				for (int u = 0; u < 2; u++)
					for (int s = 0; s < 4; s++)
					begin
						{en_s, en_p} = e[1:0];
						{pe, se, pp, sp} = {s == 0, s == 1, s == 2, s == 3};
						wr = (k != 0);
						dly = (k == 2);
						pd = u[0] & en_p & (pe | pp);
						sd = !u[0] & en_s & (se | sp);
						ppin = (en_p & pe & ((u[0] & !wr) | (!u[0] & wr)))
							| (!u[0] & dly & sp & en_p & en_s);
						spin = (en_s & se & ((!u[0] & !wr) | (u[0] & wr)))
							| (u[0] & dly & pp & en_p & en_s);
						report(xact_t'(k), u[0], pe, se, pp, sp);
						check({30'h0, poe, pn}, {30'h0, ppin, !ppin});
						check({30'h0, soe, sn}, {30'h0, spin, !spin});
						@(posedge i_mclk);
						#1 check({30'h0, poe, soe, pn, sn}, {30'h0, ppin, spin, 2'h3});
						reg_rd(STATUS_OFFSET, rd);
						check(rd[0], pd);
						check(rd[1], sd);
						reg_wr(STATUS_OFFSET, 32'h3);
						repeat (2) @(posedge i_mclk);
					end
		end
		// A set bit survives a clean report and a write of zero, and clears on one.
		reg_wr(CTRL_OFFSET, 32'h3);
		// The read lands while the pin is low, so the drive bits are seen set.
		fork
			report(XACT_READ, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
			begin
				@(posedge i_mclk);
				reg_rd(STATUS_OFFSET, rd);
			end
		join
		check(rd[3:0], 4'h5);
		fork
			report(XACT_READ, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
			begin
				@(posedge i_mclk);
				reg_rd(STATUS_OFFSET, rd);
			end
		join
		check(rd[3:0], 4'hb);
		report(XACT_POSTED_WRITE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		report(XACT_READ, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		reg_wr(STATUS_OFFSET, 32'h0);
		reg_rd(STATUS_OFFSET, rd);
		check(rd[1:0], 2'h3);
		reg_wr(STATUS_OFFSET, 32'h1);
		reg_rd(STATUS_OFFSET, rd);
		check(rd[1:0], 2'h2);
		tally_and_finish;
	end

	// Watchdog: the sweep needs about 900 cycles, so 100 us means a hang.
	initial
	begin
		#100000;
		error_cnt++;
		tally_and_finish;
	end
endmodule
